// ==== design/mss_module_state_sequencer.sv ====
// Purpose: module-side state sequencer with control register port
// Assumes: all inputs synchronous to clk_sys; sub-functions answer
//          each transient state with a done or fail level
// Notes: rst models supply power-on and hot-plug
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "mss_defs.svh"

module mss_module_state_sequencer #(
    parameter int unsigned LANES = 4,
    parameter logic [15:0] FAULT_MASK = `MSS_FAULT_MASK,
    parameter int unsigned INIT_MAX_CYC = `MSS_INIT_MAX_CYC,
    parameter logic [15:0] HPUP_MAX_MS = `MSS_HPUP_MAX_MS,
    parameter logic [15:0] TXON_MAX_MS = `MSS_TXON_MAX_MS,
    parameter int unsigned HPUP_MAX_CYC = `MSS_HPUP_MAX_MS * `MSS_CLK_KHZ,
    parameter int unsigned TXON_MAX_CYC = `MSS_TXON_MAX_MS * `MSS_CLK_KHZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mss_pkg::mss_bus_s bus,
    output logic [15:0] rdata,
    input wire logic reset_pin_low,
    input wire logic low_power_pin,
    input wire logic transmit_off_pin,
    input wire logic supplyLow,
    input wire logic cooling_interlock,
    input wire logic [15:0] faultStatus,
    input wire logic fawsEvent,
    input wire mss_pkg::mss_hshk_s hshk,
    output mss_pkg::mss_state_e moduleState,
    output logic mgmtHold,
    output logic circuitReset,
    output logic highPowerEnable,
    output logic hostLaneStatic,
    output logic [LANES-1:0] laneTxEnable,
    output logic global_alert_pin_low,
    output logic high_power_active,
    output logic module_ready_flag,
    output logic module_fault_flag,
    output logic [2:0] programmable_alert_pins
);
    import mss_pkg::*;

    initial begin
        if (LANES < 1 || LANES > 16) begin
            $error("LANES must be 1 to 16");
        end
        if (INIT_MAX_CYC < 1 || HPUP_MAX_CYC < 1 || TXON_MAX_CYC < 1) begin
            $error("time limits must be at least one cycle");
        end
    end

    mss_state_e state_reg;
    mss_state_e state_next;
    mss_ctrl_s ctrl_reg;
    logic [LANES-1:0] laneTxDis_reg;
    logic [31:0] timer_reg;
    logic [31:0] timerLimit;
    logic timedState;
    logic timeout;
    logic globalAlert_reg;
    logic [15:0] rdata_reg;
    logic combinedResetRequest;
    logic combinedLowPowerRequest;
    logic combinedTransmitOff;
    logic faultAny;
    logic holdPort;
    logic busWrite;
    logic alertRead;
    logic [15:0] stateBits;
    logic [15:0] laneRead;

    assign combinedResetRequest = !reset_pin_low || ctrl_reg.softReset ||
                                  supplyLow;
    assign combinedLowPowerRequest = low_power_pin || ctrl_reg.softLowPower ||
                                     cooling_interlock;
    assign combinedTransmitOff = transmit_off_pin || ctrl_reg.softTxOff;
    assign faultAny = |(faultStatus & FAULT_MASK);

    // port held in reset and init
    assign holdPort = (state_reg == MSS_RESET) || (state_reg == MSS_INIT);
    assign busWrite = bus.we && !holdPort;
    assign alertRead = bus.re && !holdPort &&
                       (bus.addr == `MSS_OFS_ALERT);

    // Only transient states carry a time limit
    always_comb begin
        timedState = 1'b1;
        timerLimit = INIT_MAX_CYC;
        unique case (state_reg)
            MSS_INIT: timerLimit = INIT_MAX_CYC;
            MSS_HPWR_UP: timerLimit = HPUP_MAX_CYC;
            MSS_TX_TURN_ON: timerLimit = TXON_MAX_CYC;
            default: timedState = 1'b0;
        endcase
    end

    assign timeout = timedState && (timer_reg >= timerLimit - 32'h1);

    always_ff @(posedge clk_sys) begin
        if (rst || state_next != state_reg || !timedState) begin
            timer_reg <= 32'h0;
        end else begin
            timer_reg <= timer_reg + 32'h1;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MSS_RESET: begin
                if (!combinedResetRequest) begin
                    state_next = MSS_INIT;
                end
            end
            MSS_INIT: begin
                if (combinedResetRequest) begin
                    state_next = MSS_RESET;
                end else if (faultAny || hshk.initFail || timeout) begin
                    state_next = MSS_FAULT;
                end else if (hshk.initDone) begin
                    state_next = MSS_LOW_POWER;
                end
            end
            MSS_LOW_POWER: begin
                if (combinedResetRequest) begin
                    state_next = MSS_RESET;
                end else if (faultAny) begin
                    state_next = MSS_FAULT;
                end else if (!combinedLowPowerRequest) begin
                    state_next = MSS_HPWR_UP;
                end
            end
            MSS_HPWR_UP: begin
                if (faultAny || hshk.pwrUpFail || timeout) begin
                    state_next = MSS_FAULT;
                end else if (hshk.pwrUpDone) begin
                    state_next = MSS_TX_OFF;
                end
            end
            MSS_TX_OFF: begin
                if (faultAny) begin
                    state_next = MSS_FAULT;
                end else if (combinedResetRequest ||
                             combinedLowPowerRequest) begin
                    state_next = MSS_HPWR_DOWN;
                end else if (!combinedTransmitOff) begin
                    state_next = MSS_TX_TURN_ON;
                end
            end
            MSS_TX_TURN_ON: begin
                if (faultAny || hshk.txOnFail || timeout) begin
                    state_next = MSS_FAULT;
                end else if (combinedResetRequest ||
                             combinedLowPowerRequest ||
                             combinedTransmitOff) begin
                    state_next = MSS_TX_TURN_OFF;
                end else if (hshk.txOnDone) begin
                    state_next = MSS_READY;
                end
            end
            MSS_READY: begin
                if (faultAny) begin
                    state_next = MSS_FAULT;
                end else if (combinedResetRequest ||
                             combinedLowPowerRequest ||
                             combinedTransmitOff) begin
                    state_next = MSS_TX_TURN_OFF;
                end
            end
            MSS_TX_TURN_OFF: begin
                if (faultAny) begin
                    state_next = MSS_FAULT;
                end else if (hshk.txOffDone) begin
                    if (combinedResetRequest || combinedLowPowerRequest) begin
                        state_next = MSS_HPWR_DOWN;
                    end else begin
                        state_next = MSS_TX_OFF;
                    end
                end
            end
            MSS_HPWR_DOWN: begin
                if (faultAny) begin
                    state_next = MSS_FAULT;
                end else if (hshk.pwrDownDone) begin
                    if (combinedResetRequest) begin
                        state_next = MSS_RESET;
                    end else begin
                        state_next = MSS_LOW_POWER;
                    end
                end
            end
            MSS_FAULT: begin
                if (combinedResetRequest) begin
                    state_next = MSS_RESET;
                end
            end
            default: state_next = MSS_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= MSS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Flags follow the next state so they change with the state itself
    // high-power, ready and fault flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            high_power_active <= 1'b0;
            module_ready_flag <= 1'b0;
            module_fault_flag <= 1'b0;
        end else begin
            high_power_active <= (state_next == MSS_TX_OFF) ||
                                 (state_next == MSS_TX_TURN_ON) ||
                                 (state_next == MSS_READY) ||
                                 (state_next == MSS_TX_TURN_OFF);
            module_ready_flag <= (state_next == MSS_READY);
            module_fault_flag <= (state_next == MSS_FAULT);
        end
    end

    assign programmable_alert_pins = {module_fault_flag, module_ready_flag,
                                      high_power_active};
    assign moduleState = state_reg;
    assign mgmtHold = holdPort;
    assign circuitReset = (state_reg == MSS_RESET);

    // high power off in low power
    assign highPowerEnable = (state_reg == MSS_HPWR_UP) ||
                             (state_reg == MSS_TX_OFF) ||
                             (state_reg == MSS_TX_TURN_ON) ||
                             (state_reg == MSS_READY) ||
                             (state_reg == MSS_TX_TURN_OFF);
    assign hostLaneStatic = !highPowerEnable;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            laneTxEnable <= '0;
        end else if (state_next == MSS_TX_TURN_ON ||
                     state_next == MSS_READY) begin
            laneTxEnable <= ~laneTxDis_reg;
        end else begin
            laneTxEnable <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_reg == MSS_RESET) begin
            ctrl_reg <= `MSS_CTL_RESET;
        end else if (busWrite && bus.addr == `MSS_OFS_CONTROL) begin
            ctrl_reg.softReset <= bus.wdata[`MSS_CTL_SOFT_RESET];
            ctrl_reg.softLowPower <= bus.wdata[`MSS_CTL_SOFT_LOW_POWER];
            ctrl_reg.softTxOff <= bus.wdata[`MSS_CTL_SOFT_TX_OFF];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_reg == MSS_RESET) begin
            laneTxDis_reg <= LANES'(`MSS_LANE_RESET);
        end else if (busWrite && bus.addr == `MSS_OFS_LANE_TRANSMIT_OFF_PIN) begin
            laneTxDis_reg <= bus.wdata[LANES-1:0];
        end
    end

    // Set wins over clear-on-read so no event is lost
    // alert at init completion
    always_ff @(posedge clk_sys) begin
        if (rst || combinedResetRequest || holdPort &&
            !(state_reg == MSS_INIT && state_next != MSS_INIT)) begin
            globalAlert_reg <= 1'b0;
        end else if ((state_reg == MSS_INIT && state_next != MSS_INIT) ||
                     fawsEvent) begin
            globalAlert_reg <= 1'b1;
        end else if (alertRead) begin
            globalAlert_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            global_alert_pin_low <= 1'b1;
        end else begin
            global_alert_pin_low <= !globalAlert_reg;
        end
    end

    always_comb begin
        stateBits = 16'h0000;
        laneRead = 16'h0000;
        laneRead[LANES-1:0] = laneTxDis_reg;
        unique case (state_reg)
            MSS_LOW_POWER: stateBits[2] = 1'b1;
            MSS_HPWR_UP: stateBits[3] = 1'b1;
            MSS_TX_OFF: stateBits[4] = 1'b1;
            MSS_TX_TURN_ON: stateBits[5] = 1'b1;
            MSS_READY: stateBits[6] = 1'b1;
            MSS_TX_TURN_OFF: stateBits[7] = 1'b1;
            MSS_HPWR_DOWN: stateBits[8] = 1'b1;
            MSS_FAULT: stateBits[9] = 1'b1;
            default: stateBits = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= `MSS_HOLD_READ;
        end else if (bus.re) begin
            if (holdPort) begin
                rdata_reg <= `MSS_HOLD_READ;
            end else begin
                unique case (bus.addr)
                    `MSS_OFS_CONTROL: rdata_reg <= {13'h0000,
                        ctrl_reg.softTxOff, ctrl_reg.softLowPower,
                        ctrl_reg.softReset};
                    `MSS_OFS_LANE_TRANSMIT_OFF_PIN: rdata_reg <= laneRead;
                    `MSS_OFS_MODULE_STATE: rdata_reg <= stateBits;
                    `MSS_OFS_FAULT_STATUS: rdata_reg <= faultStatus &
                        FAULT_MASK;
                    `MSS_OFS_MAX_HPUP_TIME: rdata_reg <= HPUP_MAX_MS;
                    `MSS_OFS_MAX_TXON_TIME: rdata_reg <= TXON_MAX_MS;
                    `MSS_OFS_ALERT: rdata_reg <= {15'h0000,
                        globalAlert_reg};
                    default: rdata_reg <= `MSS_UNMAPPED_READ;
                endcase
            end
        end
    end

    assign rdata = rdata_reg;

endmodule // mss_module_state_sequencer

// ==== pkg/mss_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz management clock
// Notes: included by the sequencer and its bench
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

`define MSS_ADDR_W 4
`define MSS_DATA_W 16

`define MSS_OFS_CONTROL 4'h0
`define MSS_OFS_LANE_TRANSMIT_OFF_PIN 4'h1
`define MSS_OFS_MODULE_STATE 4'h2
`define MSS_OFS_FAULT_STATUS 4'h3
`define MSS_OFS_MAX_HPUP_TIME 4'h4
`define MSS_OFS_MAX_TXON_TIME 4'h5
`define MSS_OFS_ALERT 4'h6

`define MSS_CTL_SOFT_RESET 0
`define MSS_CTL_SOFT_LOW_POWER 1
`define MSS_CTL_SOFT_TX_OFF 2
`define MSS_ALERT_GLOBAL 0

`define MSS_CTL_RESET 3'h0
`define MSS_LANE_RESET 16'h0000
`define MSS_HOLD_READ 16'hFFFF
`define MSS_UNMAPPED_READ 16'h0000
`define MSS_FAULT_MASK 16'hFFFE

`define MSS_CLK_KHZ 25000
`define MSS_INIT_MAX_MS 2500
`define MSS_INIT_MAX_CYC (`MSS_INIT_MAX_MS * `MSS_CLK_KHZ)
`define MSS_HPUP_MAX_MS 200
`define MSS_TXON_MAX_MS 100

`endif

// ==== pkg/mss_pkg.sv ====
// Purpose: types for the module state sequencer
// Assumes: constants live in mss_defs.svh
// Notes: state codes step as Gray code along the start-up path
package mss_pkg;

    typedef enum logic [3:0] {
        MSS_RESET = 4'h0,
        MSS_INIT = 4'h1,
        MSS_LOW_POWER = 4'h3,
        MSS_HPWR_UP = 4'h2,
        MSS_TX_OFF = 4'h6,
        MSS_TX_TURN_ON = 4'h7,
        MSS_READY = 4'h5,
        MSS_TX_TURN_OFF = 4'h4,
        MSS_HPWR_DOWN = 4'hC,
        MSS_FAULT = 4'h8
    } mss_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } mss_bus_s;

    typedef struct packed {
        logic initDone;
        logic initFail;
        logic pwrUpDone;
        logic pwrUpFail;
        logic txOnDone;
        logic txOnFail;
        logic txOffDone;
        logic pwrDownDone;
    } mss_hshk_s;

    typedef struct packed {
        logic softTxOff;
        logic softLowPower;
        logic softReset;
    } mss_ctrl_s;

endpackage

// ==== sim/mss_subfunc_model.sv ====
// Purpose: sub-function responder answering transient-state handshakes
// Assumes: moduleState is registered in the sequencer
// Notes: slow mode answers 6 cycles after state entry
`timescale 1ns/100ps
module mss_subfunc_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mss_pkg::mss_state_e moduleState,
    input wire logic [2:0] failSel,
    input wire logic slow,
    output mss_pkg::mss_hshk_s hshk
);
    import mss_pkg::*;
    mss_state_e seenReg;
    logic [3:0] waitReg;
    logic due;
    always_ff @(posedge clk_sys) begin
        seenReg <= moduleState;
        if (rst || moduleState != seenReg) begin
            waitReg <= 4'h0;
        end else if (waitReg != 4'hF) begin
            waitReg <= waitReg + 4'h1;
        end
    end
    // Count restarts on entry, so a stale count never answers early
    assign due = !slow || (moduleState == seenReg && waitReg >= 4'h5);
    always_comb begin
        hshk = '0;
        hshk.initDone = due && moduleState == MSS_INIT && !failSel[0];
        hshk.initFail = due && moduleState == MSS_INIT && failSel[0];
        hshk.pwrUpDone = due && moduleState == MSS_HPWR_UP && !failSel[1];
        hshk.pwrUpFail = due && moduleState == MSS_HPWR_UP && failSel[1];
        hshk.txOnDone = due && moduleState == MSS_TX_TURN_ON && !failSel[2];
        hshk.txOnFail = due && moduleState == MSS_TX_TURN_ON && failSel[2];
        hshk.txOffDone = due && moduleState == MSS_TX_TURN_OFF;
        hshk.pwrDownDone = due && moduleState == MSS_HPWR_DOWN;
    end
endmodule // mss_subfunc_model

// ==== sim/mss_sequencer_monitor.sv ====
// Purpose: port checker for the module state sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: soft register bits are unseen, so only pin, supplyLow and cooling requests are used
`timescale 1ns/100ps
module mss_sequencer_monitor
import mss_pkg::*;
#(
    parameter int unsigned LANES = 4,
    parameter logic [15:0] FAULT_MASK = 16'hFFFE
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mss_pkg::mss_bus_s bus,
    input wire logic [15:0] rdata,
    input wire logic reset_pin_low,
    input wire logic low_power_pin,
    input wire logic transmit_off_pin,
    input wire logic supplyLow,
    input wire logic cooling_interlock,
    input wire logic [15:0] faultStatus,
    input wire mss_pkg::mss_state_e moduleState,
    input wire logic mgmtHold,
    input wire logic [LANES-1:0] laneTxEnable,
    input wire logic global_alert_pin_low,
    input wire logic high_power_active,
    input wire logic module_ready_flag,
    input wire logic module_fault_flag,
    input wire logic [2:0] programmable_alert_pins
);
    logic pinReset;
    logic faultAny;
    logic hiPwr;
    logic anyReq;
    assign pinReset = !reset_pin_low || supplyLow;
    assign faultAny = (faultStatus & FAULT_MASK) != 16'h0000;
    assign hiPwr = moduleState inside {MSS_TX_OFF, MSS_TX_TURN_ON,
        MSS_READY, MSS_TX_TURN_OFF};
    assign anyReq = pinReset || low_power_pin || cooling_interlock ||
        transmit_off_pin;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence init_leaves;
        moduleState == MSS_INIT ##1 moduleState == MSS_LOW_POWER;
    endsequence
    sequence reset_released;
        moduleState == MSS_RESET && !pinReset ##1 !pinReset;
    endsequence
    a_hold_reads: assert property (bus.re && mgmtHold |=> rdata == 16'hFFFF)
        else $error("read during hold not all ones");
    a_reset_stays: assert property (moduleState == MSS_RESET && pinReset
        |=> moduleState == MSS_RESET) else $error("reset left early");
    a_reset_exit: assert property (reset_released
        |=> moduleState != MSS_RESET) else $error("reset not left");
    a_lowpwr_stays: assert property (moduleState == MSS_LOW_POWER &&
        (low_power_pin || cooling_interlock) && !pinReset && !faultAny
        |=> moduleState == MSS_LOW_POWER) else $error("low power left");
    a_ready_quits: assert property (moduleState == MSS_READY && anyReq &&
        !faultAny |=> moduleState == MSS_TX_TURN_OFF)
        else $error("ready not left via turn-off");
    a_fault_entry: assert property (faultAny && !pinReset &&
        moduleState != MSS_RESET |=> moduleState == MSS_FAULT)
        else $error("fault not entered");
    a_fault_holds: assert property (moduleState == MSS_FAULT && !pinReset
        |=> moduleState == MSS_FAULT) else $error("fault left");
    a_state_flags: assert property (module_ready_flag ==
        (moduleState == MSS_READY) && module_fault_flag ==
        (moduleState == MSS_FAULT)) else $error("state flags wrong");
    a_hipwr_flag: assert property (high_power_active == hiPwr)
        else $error("high power flag wrong");
    a_prog_pins: assert property (programmable_alert_pins == {module_fault_flag,
        module_ready_flag, high_power_active}) else $error("alert pins wrong");
    a_lanes_dark: assert property (moduleState inside {MSS_TX_OFF,
        MSS_TX_TURN_OFF} |-> laneTxEnable == '0) else $error("lane lit");
    a_alert_init: assert property (init_leaves |=> !global_alert_pin_low)
        else $error("alert pin not low after init");
endmodule // mss_sequencer_monitor

bind mss_module_state_sequencer mss_sequencer_monitor #(.LANES(LANES),
    .FAULT_MASK(FAULT_MASK)) u_monitor (.clk_sys(clk_sys), .rst(rst),
    .bus(bus), .rdata(rdata), .reset_pin_low(reset_pin_low),
    .low_power_pin(low_power_pin), .transmit_off_pin(transmit_off_pin),
    .supplyLow(supplyLow), .cooling_interlock(cooling_interlock),
    .faultStatus(faultStatus), .moduleState(moduleState),
    .mgmtHold(mgmtHold), .laneTxEnable(laneTxEnable),
    .global_alert_pin_low(global_alert_pin_low),
    .high_power_active(high_power_active),
    .module_ready_flag(module_ready_flag),
    .module_fault_flag(module_fault_flag),
    .programmable_alert_pins(programmable_alert_pins));

// ==== sim/module_state_sequencer_tb.sv ====
// Purpose: self-checking bench for the module state sequencer
// Assumes: short transient limits of 40 cycles
// Notes: fawsEvent held low; alert path covered by init exit
`timescale 1ns/100ps
`include "mss_defs.svh"
module module_state_sequencer_tb;
    import mss_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, slow = 1'b1;
    mss_bus_s bus = '0;
    logic [15:0] rdata, faultStatus = 16'h0000;
    logic reset_pin_low = 1'b0, low_power_pin = 1'b1;
    logic transmit_off_pin = 1'b1, supplyLow = 1'b0, cooling = 1'b0;
    logic [2:0] failSel = 3'h0, progPins;
    mss_hshk_s hshk;
    mss_state_e moduleState;
    logic [3:0] laneTxEnable;
    logic hiPwr, readyFlag, faultFlag, hpEn;
    int bad_count = 0, checks = 0;
    logic [3:0] rowAddr [6] = '{`MSS_OFS_MODULE_STATE,
        `MSS_OFS_MAX_HPUP_TIME, `MSS_OFS_MAX_TXON_TIME,
        `MSS_OFS_FAULT_STATUS, `MSS_OFS_LANE_TRANSMIT_OFF_PIN, 4'hF};
    logic [15:0] rowExp [6] = '{16'h0040, 16'h00C8, 16'h0064,
        16'h0000, 16'h0005, 16'h0000};
    always #20 clk_sys = ~clk_sys;
    mss_module_state_sequencer #(.INIT_MAX_CYC(40), .HPUP_MAX_CYC(40),
        .TXON_MAX_CYC(40)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .bus(bus), .rdata(rdata), .reset_pin_low(reset_pin_low),
        .low_power_pin(low_power_pin), .transmit_off_pin(transmit_off_pin),
        .supplyLow(supplyLow), .cooling_interlock(cooling),
        .faultStatus(faultStatus), .fawsEvent(1'b0), .hshk(hshk),
        .moduleState(moduleState), .mgmtHold(), .circuitReset(),
        .highPowerEnable(hpEn), .hostLaneStatic(), .laneTxEnable(laneTxEnable),
        .global_alert_pin_low(), .high_power_active(hiPwr),
        .module_ready_flag(readyFlag), .module_fault_flag(faultFlag),
        .programmable_alert_pins(progPins));
    mss_subfunc_model u_model (.clk_sys(clk_sys), .rst(rst),
        .moduleState(moduleState), .failSel(failSel), .slow(slow),
        .hshk(hshk));
    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        bus <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task automatic waitState(input mss_state_e st);
        int i;
        for (i = 0; i < 300 && moduleState !== st; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("moduleState", {12'h000, st}, {12'h000, moduleState});
        if (moduleState !== st) complete_run();
    endtask
    task automatic stay(input mss_state_e st, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            chk("moduleState", {12'h000, st}, {12'h000, moduleState});
        end
    endtask
    task automatic downTo(input mss_state_e st);
        waitState(MSS_TX_TURN_OFF);
        waitState(MSS_HPWR_DOWN);
        waitState(st);
        chk("highPower", 16'h0000, {15'h0, hiPwr});
        chk("highPowerEnable", 16'h0000, {15'h0, hpEn});
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        stay(MSS_RESET, 5);
        rd(`MSS_OFS_CONTROL, 16'hFFFF);
        wr(`MSS_OFS_LANE_TRANSMIT_OFF_PIN, 16'h000F);
        @(posedge clk_sys);
        reset_pin_low <= 1'b1;
        waitState(MSS_LOW_POWER);
        rd(`MSS_OFS_LANE_TRANSMIT_OFF_PIN, 16'h0000);
        rd(`MSS_OFS_ALERT, 16'h0001);
        rd(`MSS_OFS_ALERT, 16'h0000);
        wr(`MSS_OFS_LANE_TRANSMIT_OFF_PIN, 16'h0005);
        low_power_pin <= 1'b0;
        waitState(MSS_HPWR_UP);
        waitState(MSS_TX_OFF);
        chk("highPower", 16'h0001, {15'h0, hiPwr});
        chk("highPowerEnable", 16'h0001, {15'h0, hpEn});
        stay(MSS_TX_OFF, 3);
        transmit_off_pin <= 1'b0;
        waitState(MSS_READY);
        chk("laneTxEnable", 16'h000A, {12'h000, laneTxEnable});
        for (int r = 0; r < 6; r++) rd(rowAddr[r], rowExp[r]);
        wr(`MSS_OFS_CONTROL, 16'h0004);
        waitState(MSS_TX_TURN_OFF);
        waitState(MSS_TX_OFF);
        rd(`MSS_OFS_LANE_TRANSMIT_OFF_PIN, 16'h0005);
        wr(`MSS_OFS_CONTROL, 16'h0000);
        waitState(MSS_READY);
        low_power_pin <= 1'b1;
        downTo(MSS_LOW_POWER);
        slow <= 1'b0;
        low_power_pin <= 1'b0;
        cooling <= 1'b1;
        stay(MSS_LOW_POWER, 10);
        cooling <= 1'b0;
        waitState(MSS_READY);
        supplyLow <= 1'b1;
        downTo(MSS_RESET);
        supplyLow <= 1'b0;
        waitState(MSS_READY);
        wr(`MSS_OFS_CONTROL, 16'h0001);
        downTo(MSS_RESET);
        waitState(MSS_READY);
        faultStatus <= 16'h0001;
        stay(MSS_READY, 5);
        faultStatus <= 16'h0010;
        waitState(MSS_FAULT);
        chk("ready", 16'h0000, {15'h0, readyFlag});
        faultStatus <= 16'h0000;
        stay(MSS_FAULT, 5);
        reset_pin_low <= 1'b0;
        waitState(MSS_RESET);
        // Each sub-function failure in turn
        for (int f = 0; f < 3; f++) begin
            failSel <= 3'h1 << f;
            reset_pin_low <= 1'b1;
            waitState(MSS_FAULT);
            chk("flags", 16'h0004, {13'h0, progPins});
            chk("highPowerEnable", 16'h0000, {15'h0, hpEn});
            reset_pin_low <= 1'b0;
            waitState(MSS_RESET);
        end
        complete_run();
    end
endmodule // module_state_sequencer_tb
